// ---- rtl/drc_pkg.sv ----
// Package for the drive reset and control mode select block.
// Assumes a single core clock domain and a synchronous active-low reset.
package drc_pkg;

    // Register offsets (word addresses on the plain register port)
    localparam logic [3:0] DRC_ADDR_CTRL    = 4'h0;
    localparam logic [3:0] DRC_ADDR_CAP     = 4'h1;
    localparam logic [3:0] DRC_ADDR_POLES   = 4'h2;
    localparam logic [3:0] DRC_ADDR_METHOD  = 4'h3;
    localparam logic [3:0] DRC_ADDR_INFUNC0 = 4'h4;
    localparam logic [3:0] DRC_ADDR_STATUS  = 4'hA;
    localparam int         DRC_NUM_INFUNC   = 5;

    // Control register fields
    localparam int DRC_CTRL_RSTSEL_BIT = 0;
    localparam int DRC_CTRL_STORE_BIT  = 1;

    // Parameter values
    localparam logic [15:0] DRC_SENTINEL    = 16'h270F;  // 9999
    localparam logic [15:0] DRC_CAP_MIN     = 16'h0001;  // 0.1 kW in 0.1 kW units
    localparam logic [15:0] DRC_CAP_MAX     = 16'h0096;  // 15 kW in 0.1 kW units
    localparam logic [15:0] DRC_POLES_2     = 16'h0002;
    localparam logic [15:0] DRC_POLES_4     = 16'h0004;
    localparam logic [15:0] DRC_POLES_6     = 16'h0006;
    localparam logic [15:0] DRC_POLES_8     = 16'h0008;
    localparam logic [15:0] DRC_POLES_10    = 16'h000A;
    localparam logic [15:0] DRC_METHOD_AFV  = 16'h0014;  // 20
    localparam logic [15:0] DRC_METHOD_GFV  = 16'h001E;  // 30
    localparam logic [15:0] DRC_INFUNC_VFSW = 16'h0012;  // 18
    localparam logic [15:0] DRC_INFUNC_RST  = 16'h270F;
    localparam logic        DRC_RSTSEL_RST  = 1'b0;
    localparam logic        DRC_STORE_RST   = 1'b0;

    // Status register fields
    localparam int DRC_ST_METHOD_LSB = 0;
    localparam int DRC_ST_HOLD_BIT   = 4;
    localparam int DRC_ST_SECOND_BIT = 5;

    // Control command blackout after reset release
    localparam int DRC_BLACKOUT_MS = 1000;
    localparam int DRC_CLK_KHZ     = 25000;
    localparam int DRC_BLACKOUT_CYC = DRC_BLACKOUT_MS * DRC_CLK_KHZ;

    // Control methods
    typedef enum logic [2:0] {
        DRC_M_VF  = 3'b001,
        DRC_M_AFV = 3'b010,
        DRC_M_GFV = 3'b100
    } drc_method_t;

endpackage

// ---- rtl/drc_sync.sv ----
// Two flip-flop synchroniser for asynchronous pin inputs.
// Assumes the destination is the core clock domain.
`timescale 1ns/1ps
module drc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_nrst,
    // Data
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    always_comb begin
        meta_next = i_async;
        sync_next = meta_reg;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign o_sync = sync_reg;
endmodule // drc_sync

// ---- rtl/drc_top.sv ----
// Reset acceptance, parameter storage routing and control method selection.
// Assumes network requests come from same-clock logic; panel, trip and run
// status come from pins and are synchronised here.
`timescale 1ns/1ps
module drc_top
    import drc_pkg::*;
#(
    parameter int BLACKOUT_CYC = DRC_BLACKOUT_CYC,
    parameter int NUM_VTERM    = 5
) (
    // Clock and reset
    input  wire logic                 i_core_clk,
    input  wire logic                 i_nrst,
    // Register port
    input  wire logic [3:0]           i_reg_addr,
    input  wire logic [15:0]          i_reg_wdata,
    input  wire logic                 i_reg_wr,
    input  wire logic                 i_reg_rd,
    output logic      [15:0]          o_reg_rdata,
    // Network requests (core clock domain)
    input  wire logic                 i_net_mode,
    input  wire logic                 i_net_err_reset_req,
    input  wire logic                 i_net_drive_reset_req,
    input  wire logic                 i_net_comm_err,
    input  wire logic                 i_net_param_wr,
    input  wire logic [NUM_VTERM-1:0] i_net_vterm,
    input  wire logic                 i_net_ctrl_cmd,
    // Pins from the drive
    input  wire logic                 i_panel_reset,
    input  wire logic                 i_trip_active,
    input  wire logic                 i_running,
    // Reset and storage outputs
    output logic                      o_error_reset,
    output logic                      o_drive_reset,
    output logic                      o_nv_write,
    output logic                      o_vol_write,
    output logic                      o_ctrl_cmd_accept,
    // Control method outputs
    output logic      [2:0]           o_method,
    output logic                      o_second_func,
    output logic                      o_change_pending,
    output logic                      o_param_range_err
);
    localparam int BW = $clog2(BLACKOUT_CYC + 1);

    logic panel_reset_s;
    logic trip_s;
    logic running_s;
    logic panel_prev_reg;
    logic panel_prev_next;

    drc_sync #(.W(3)) u_sync (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_async    ({i_panel_reset, i_trip_active, i_running}),
        .o_sync     ({panel_reset_s, trip_s, running_s})
    );

    // Parameter registers; power-up reset reloads defaults, volatile copy lost
    logic        rstsel_reg;
    logic        rstsel_next;
    logic        store_reg;
    logic        store_next;
    logic [15:0] cap_reg;
    logic [15:0] cap_next;
    logic [15:0] poles_reg;
    logic [15:0] poles_next;
    logic [15:0] method_reg;
    logic [15:0] method_next;
    logic [15:0] infunc_reg  [DRC_NUM_INFUNC];
    logic [15:0] infunc_next [DRC_NUM_INFUNC];
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic        range_err_reg;
    logic        range_err_next;

    function automatic logic poles_ok(input logic [15:0] v);
        poles_ok = (v == DRC_POLES_2) || (v == DRC_POLES_4) || (v == DRC_POLES_6)
                || (v == DRC_POLES_8) || (v == DRC_POLES_10) || (v == DRC_SENTINEL);
    endfunction

    // Selects sit at consecutive word addresses
    function automatic logic infunc_hit(input logic [3:0] a, input int k);
        infunc_hit = (a == DRC_ADDR_INFUNC0 + 4'(k));
    endfunction

    function automatic logic cap_ok(input logic [15:0] v);
        cap_ok = ((v >= DRC_CAP_MIN) && (v <= DRC_CAP_MAX)) || (v == DRC_SENTINEL);
    endfunction

    always_comb begin
        rstsel_next    = rstsel_reg;
        store_next     = store_reg;
        cap_next       = cap_reg;
        poles_next     = poles_reg;
        method_next    = method_reg;
        range_err_next = range_err_reg;
        for (int k = 0; k < DRC_NUM_INFUNC; k++) begin
            infunc_next[k] = infunc_reg[k];
        end
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                DRC_ADDR_CTRL: begin
                    rstsel_next = i_reg_wdata[DRC_CTRL_RSTSEL_BIT];
                    store_next  = i_reg_wdata[DRC_CTRL_STORE_BIT];
                end
                DRC_ADDR_CAP: begin
                    if (cap_ok(i_reg_wdata)) cap_next = i_reg_wdata;
                    else range_err_next = 1'b1;
                end
                DRC_ADDR_POLES: begin
                    if (poles_ok(i_reg_wdata)) poles_next = i_reg_wdata;
                    else range_err_next = 1'b1;
                end
                DRC_ADDR_METHOD: begin
                    if (i_reg_wdata == DRC_METHOD_AFV || i_reg_wdata == DRC_METHOD_GFV)
                        method_next = i_reg_wdata;
                    else range_err_next = 1'b1;
                end
                DRC_ADDR_STATUS: range_err_next = 1'b0;
                default: begin
                    for (int k = 0; k < DRC_NUM_INFUNC; k++) begin
                        if (infunc_hit(i_reg_addr, k))
                            infunc_next[k] = i_reg_wdata;
                    end
                end
            endcase
        end
    end

    // Reset acceptance; mode and selection read combinationally in request cycle
    logic err_rst_reg;
    logic err_rst_next;
    logic drv_rst_reg;
    logic drv_rst_next;
    logic [BW-1:0] blk_cnt_reg;
    logic [BW-1:0] blk_cnt_next;
    logic net_err_ok;
    logic net_drv_ok;
    logic panel_edge;

    always_comb begin
        panel_prev_next = panel_reset_s;
        panel_edge      = panel_reset_s && !panel_prev_reg;
        net_err_ok = i_net_err_reset_req && trip_s && !i_net_comm_err
                  && (rstsel_reg == 1'b0 || i_net_mode);
        net_drv_ok = i_net_drive_reset_req && i_net_mode && !i_net_comm_err;
        err_rst_next = net_err_ok || (panel_edge && trip_s);
        drv_rst_next = net_drv_ok;
        if (drv_rst_reg)
            blk_cnt_next = BW'(BLACKOUT_CYC);
        else if (blk_cnt_reg != '0)
            blk_cnt_next = blk_cnt_reg - 1'b1;
        else
            blk_cnt_next = blk_cnt_reg;
    end

    // Control method; changes while running held until stop
    drc_method_t req_method;
    drc_method_t act_method_reg;
    drc_method_t act_method_next;
    logic        second_reg;
    logic        second_next;
    logic        vf_switch;
    wire logic [NUM_VTERM-1:0] vterm_hit;

    // One match per terminal; terminals without a select never switch
    for (genvar g = 0; g < NUM_VTERM; g++) begin : g_vterm
        if (g < DRC_NUM_INFUNC) begin : g_sel
            assign vterm_hit[g] = (infunc_reg[g] == DRC_INFUNC_VFSW)
                               && i_net_vterm[g];
        end else begin : g_none
            assign vterm_hit[g] = 1'b0;
        end
    end

    always_comb begin
        vf_switch = |vterm_hit;
        if (cap_reg == DRC_SENTINEL || poles_reg == DRC_SENTINEL || vf_switch)
            req_method = DRC_M_VF;
        else if (method_reg == DRC_METHOD_GFV)
            req_method = DRC_M_GFV;
        else
            req_method = DRC_M_AFV;
        act_method_next = act_method_reg;
        second_next     = second_reg;
        if (!running_s) begin
            act_method_next = req_method;
            second_next     = 1'b0;
        end else if (req_method == DRC_M_VF && act_method_reg != DRC_M_VF) begin
            second_next = 1'b1;
        end
    end

    always_comb begin
        rdata_next = '0;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                DRC_ADDR_CTRL: begin
                    rdata_next[DRC_CTRL_RSTSEL_BIT] = rstsel_reg;
                    rdata_next[DRC_CTRL_STORE_BIT]  = store_reg;
                end
                DRC_ADDR_CAP:    rdata_next = cap_reg;
                DRC_ADDR_POLES:  rdata_next = poles_reg;
                DRC_ADDR_METHOD: rdata_next = method_reg;
                DRC_ADDR_STATUS: begin
                    rdata_next[DRC_ST_METHOD_LSB +: 3] = act_method_reg;
                    rdata_next[DRC_ST_HOLD_BIT]        = (req_method != act_method_reg);
                    rdata_next[DRC_ST_SECOND_BIT]      = second_reg;
                end
                default: begin
                    for (int k = 0; k < DRC_NUM_INFUNC; k++) begin
                        if (infunc_hit(i_reg_addr, k))
                            rdata_next = infunc_reg[k];
                    end
                end
            endcase
        end
    end

    // Parameter state; a power cycle is this same reset
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            rstsel_reg     <= DRC_RSTSEL_RST;
            store_reg      <= DRC_STORE_RST;
            cap_reg        <= DRC_SENTINEL;
            poles_reg      <= DRC_SENTINEL;
            method_reg     <= DRC_METHOD_AFV;
            for (int k = 0; k < DRC_NUM_INFUNC; k++) infunc_reg[k] <= DRC_INFUNC_RST;
            range_err_reg  <= 1'b0;
        end else begin
            rstsel_reg     <= rstsel_next;
            store_reg      <= store_next;
            cap_reg        <= cap_next;
            poles_reg      <= poles_next;
            method_reg     <= method_next;
            infunc_reg     <= infunc_next;
            range_err_reg  <= range_err_next;
        end
    end

    // Read data stands one cycle only
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            rdata_reg      <= '0;
        end else begin
            rdata_reg      <= rdata_next;
        end
    end

    // Reset acceptance and control blackout
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            panel_prev_reg <= 1'b0;
            err_rst_reg    <= 1'b0;
            drv_rst_reg    <= 1'b0;
            blk_cnt_reg    <= '0;
        end else begin
            panel_prev_reg <= panel_prev_next;
            err_rst_reg    <= err_rst_next;
            drv_rst_reg    <= drv_rst_next;
            blk_cnt_reg    <= blk_cnt_next;
        end
    end

    // Active method; V/F until the motor settings are valid
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            act_method_reg <= DRC_M_VF;
            second_reg     <= 1'b0;
        end else begin
            act_method_reg <= act_method_next;
            second_reg     <= second_next;
        end
    end

    // Power removal is the i_nrst pin itself; no logic needed for it.
    assign o_reg_rdata       = rdata_reg;
    assign o_error_reset     = err_rst_reg;
    assign o_drive_reset     = drv_rst_reg;
    assign o_nv_write        = i_net_param_wr && (store_reg == 1'b0);
    assign o_vol_write       = i_net_param_wr;
    assign o_ctrl_cmd_accept = i_net_ctrl_cmd && !drv_rst_reg
                            && (blk_cnt_reg == '0);
    assign o_method          = act_method_reg;
    assign o_second_func     = second_reg;
    assign o_change_pending  = (req_method != act_method_reg);
    assign o_param_range_err = range_err_reg;
endmodule // drc_top

// ---- verification/drc_net_master.sv ----
// Network master model: mode, line error, requests and virtual terminals.
// Assumes requests launch just after a rising edge of the core clock.
`timescale 1ns/1ps
module drc_net_master (
    // Clock
    input  wire logic i_core_clk,
    // Link state and requests
    output logic       o_mode,
    output logic       o_comm_err,
    output logic       o_err_req,
    output logic       o_drv_req,
    output logic       o_param_wr,
    output logic       o_ctrl_cmd,
    output logic [4:0] o_vterm
);
    initial begin
        o_mode = 1'b0;
        o_comm_err = 1'b0;
        o_err_req = 1'b0;
        o_drv_req = 1'b0;
        o_param_wr = 1'b0;
        o_ctrl_cmd = 1'b0;
        o_vterm = 5'h00;
    end
    // Raise one request; 0 error reset, 1 drive reset, 2 write, 3 control
    // Mode and line error only move between requests, never with one
    task automatic put(input int k);
        @(posedge i_core_clk);
        case (k)
            0: o_err_req <= 1'b1;
            1: o_drv_req <= 1'b1;
            2: o_param_wr <= 1'b1;
            default: o_ctrl_cmd <= 1'b1;
        endcase
    endtask
    // Mode and line error; called just after a clock edge
    task automatic link(input logic m, input logic e);
        o_mode <= m;
        o_comm_err <= e;
    endtask
    task automatic terms(input logic [4:0] v);
        o_vterm <= v;
    endtask
    // Control after a drive reset is only probed, never relied on
    task automatic drop();
        @(posedge i_core_clk);
        o_err_req <= 1'b0;
        o_drv_req <= 1'b0;
        o_param_wr <= 1'b0;
        o_ctrl_cmd <= 1'b0;
    endtask
endmodule // drc_net_master

// ---- verification/drc_top_assertions.sv ----
// Checker for reset acceptance, storage strobes and method outputs.
// Assumes bind into drc_top; pins pass two flops inside the design.
`timescale 1ns/1ps
module drc_top_chk
    import drc_pkg::*;
#(
    parameter int BLACKOUT_CYC = 20,
    parameter int NUM_VTERM    = 5
) (
    // Clock and reset
    input wire logic        i_core_clk,
    input wire logic        i_nrst,
    // Inputs watched
    input wire logic        i_reg_rd,
    input wire logic        i_net_mode,
    input wire logic        i_net_drive_reset_req,
    input wire logic        i_net_comm_err,
    input wire logic        i_net_param_wr,
    input wire logic        i_net_ctrl_cmd,
    input wire logic        i_trip_active,
    input wire logic        i_running,
    // Outputs checked
    input wire logic [15:0] o_reg_rdata,
    input wire logic        o_error_reset,
    input wire logic        o_drive_reset,
    input wire logic        o_nv_write,
    input wire logic        o_vol_write,
    input wire logic        o_ctrl_cmd_accept,
    input wire logic [2:0]  o_method,
    input wire logic        o_second_func
);
    int blk_reg;
    int blk_next;
    always_comb begin
        blk_next = blk_reg;
        if (o_drive_reset)
            blk_next = BLACKOUT_CYC;
        else if (blk_reg != 0)
            blk_next = blk_reg - 1;
    end
    always_ff @(posedge i_core_clk) begin
        blk_reg <= !i_nrst ? 0 : blk_next;
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    a_drv_accept: assert property (i_net_drive_reset_req && i_net_mode && !i_net_comm_err
        |=> o_drive_reset) else $error("drive reset dropped");
    a_drv_cause: assert property (o_drive_reset |-> $past(i_net_drive_reset_req)
        && $past(i_net_mode) && !$past(i_net_comm_err)) else $error("drive reset unasked");
    a_err_trip: assert property (o_error_reset
        |-> $past(i_trip_active, 3) || $past(i_trip_active, 4)) else $error("reset without trip");
    a_store_route: assert property ((o_vol_write == i_net_param_wr)
        && (!o_nv_write || i_net_param_wr)) else $error("storage strobe wrong");
    a_blackout_hold: assert property (blk_reg != 0 |-> !o_ctrl_cmd_accept)
        else $error("control passed in blackout");
    a_cmd_pass: assert property (blk_reg == 0 && !o_drive_reset && i_net_mode
        |-> o_ctrl_cmd_accept == i_net_ctrl_cmd) else $error("control blocked late");
    a_method_hot: assert property ($onehot(o_method))
        else $error("method not one-hot");
    a_run_hold: assert property (i_running && $past(i_running) && $past(i_running, 2)
        && $past(i_running, 3) |-> $stable(o_method)) else $error("method moved in run");
    a_second_run: assert property (o_second_func |-> $past(i_running)
        || $past(i_running, 2) || $past(i_running, 3) || $past(i_running, 4))
        else $error("second set while stopped");
    a_reset_vf: assert property (disable iff (1'b0) !i_nrst |=> o_method == DRC_M_VF
        && !o_drive_reset && !o_error_reset) else $error("reset defaults wrong");
    a_rdata_idle: assert property (!i_reg_rd |=> o_reg_rdata == 16'h0000)
        else $error("read data without read");
    c_drv: cover property (o_drive_reset);
    c_err: cover property (o_error_reset);
    c_second: cover property (o_second_func);
    c_nv: cover property (o_nv_write);
endmodule // drc_top_chk
bind drc_top drc_top_chk #(.BLACKOUT_CYC(BLACKOUT_CYC), .NUM_VTERM(NUM_VTERM)) chk_i (.*);

// ---- verification/tb_top.sv ----
// Self-checking bench for drc_top with a network master model.
// Assumes a 25 MHz clock and a shortened control blackout.
`timescale 1ns/1ps
module tb_top;
    import drc_pkg::*;
    typedef struct {
        logic [15:0] cap;
        logic [15:0] pol;
        logic [15:0] mth;
        drc_method_t exp;
    } drc_row_t;
    logic        clk, nrst, wr_s, rd_s, panel, trip, run;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, d;
    logic        mode, comm, ereq, dreq, pwr, cmd;
    logic [4:0]  vterm;
    logic        err_o, drv_o, nv_o, vol_o, acc_o, sec_o, pend_o, rng_o;
    logic [2:0]  meth_o;
    int          bad_count = 0, checks_done = 0, cyc = 0;
    drc_row_t rows [6] = '{
        '{DRC_SENTINEL, DRC_SENTINEL, 16'h0014, DRC_M_VF},
        '{16'h000A, 16'h0004, 16'h0014, DRC_M_AFV},
        '{16'h0096, 16'h000A, 16'h001E, DRC_M_GFV},
        '{16'h0001, 16'h0002, 16'h0014, DRC_M_AFV},
        '{16'h000A, DRC_SENTINEL, 16'h001E, DRC_M_VF},
        '{DRC_SENTINEL, 16'h0004, 16'h0014, DRC_M_VF}};
    drc_net_master drc_net_master_i (.i_core_clk(clk), .o_mode(mode), .o_comm_err(comm),
        .o_err_req(ereq), .o_drv_req(dreq), .o_param_wr(pwr), .o_ctrl_cmd(cmd), .o_vterm(vterm));
    drc_top #(.BLACKOUT_CYC(20)) drc_top_i (.i_core_clk(clk), .i_nrst(nrst),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr_s), .i_reg_rd(rd_s),
        .o_reg_rdata(rdata), .i_net_mode(mode), .i_net_err_reset_req(ereq),
        .i_net_drive_reset_req(dreq), .i_net_comm_err(comm), .i_net_param_wr(pwr),
        .i_net_vterm(vterm), .i_net_ctrl_cmd(cmd), .i_panel_reset(panel),
        .i_trip_active(trip), .i_running(run), .o_error_reset(err_o), .o_drive_reset(drv_o),
        .o_nv_write(nv_o), .o_vol_write(vol_o), .o_ctrl_cmd_accept(acc_o), .o_method(meth_o),
        .o_second_func(sec_o), .o_change_pending(pend_o), .o_param_range_err(rng_o));
    always #20 clk = ~clk;
    task automatic close_out();
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Ceiling well above the roughly 330 cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic do_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
    endtask
    initial begin
        {clk, nrst, wr_s, rd_s, panel, trip, run} = 7'h00;
        addr = 4'h0;
        wdata = 16'h0000;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            wr(DRC_ADDR_CAP, rows[i].cap);
            wr(DRC_ADDR_POLES, rows[i].pol);
            wr(DRC_ADDR_METHOD, rows[i].mth);
            repeat (2) @(posedge clk);
            #1 chk(meth_o, rows[i].exp);
        end
        // Volatile-only values must not survive a power cycle
        wr(DRC_ADDR_CTRL, 16'h0002);
        wr(DRC_ADDR_CAP, 16'h000A);
        do_reset();
        rd(DRC_ADDR_CAP, d);
        chk(d, DRC_SENTINEL);
        rd(DRC_ADDR_POLES, d);
        chk(d, DRC_SENTINEL);
        rd(DRC_ADDR_METHOD, d);
        chk(d, DRC_METHOD_AFV);
        rd(DRC_ADDR_INFUNC0, d);
        chk(d, DRC_INFUNC_RST);
        rd(DRC_ADDR_CTRL, d);
        chk(d, 16'h0000);
        rd(4'hF, d);
        chk(d, 16'h0000);
        chk(meth_o, DRC_M_VF);
        wr(DRC_ADDR_CAP, 16'h0097);
        chk(rng_o, 1'b1);
        wr(DRC_ADDR_POLES, 16'h0003);
        rd(DRC_ADDR_CAP, d);
        chk(d, DRC_SENTINEL);
        rd(DRC_ADDR_POLES, d);
        chk(d, DRC_SENTINEL);
        wr(DRC_ADDR_STATUS, 16'h0000);
        chk(rng_o, 1'b0);
        wr(DRC_ADDR_METHOD, 16'h0015);
        chk(rng_o, 1'b1);
        rd(DRC_ADDR_METHOD, d);
        chk(d, DRC_METHOD_AFV);
        wr(DRC_ADDR_STATUS, 16'h0000);
        for (int s = 0; s < 2; s++) begin
            wr(DRC_ADDR_CTRL, s ? 16'h0002 : 16'h0000);
            drc_net_master_i.put(2);
            #1 chk(nv_o, s == 0);
            chk(vol_o, 1'b1);
            drc_net_master_i.drop();
        end
        for (int k = 0; k < 16; k++) begin
            wr(DRC_ADDR_CTRL, {15'h0000, k[0]});
            @(posedge clk);
            trip <= k[1];
            drc_net_master_i.link(k[2], k[3]);
            repeat (3) @(posedge clk);
            drc_net_master_i.put(0);
            drc_net_master_i.drop();
            #1 chk(err_o, k[1] && !k[3] && (!k[0] || k[2]));
            drc_net_master_i.put(1);
            drc_net_master_i.drop();
            #1 chk(drv_o, k[2] && !k[3]);
        end
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            drc_net_master_i.link(m[0], 1'b1);
            panel <= 1'b1;
            repeat (3) @(posedge clk);
            #1 chk(err_o, 1'b1);
            @(posedge clk);
            panel <= 1'b0;
            repeat (3) @(posedge clk);
        end
        @(posedge clk);
        drc_net_master_i.link(1'b1, 1'b0);
        drc_net_master_i.put(1);
        drc_net_master_i.drop();
        repeat (19) @(posedge clk);
        drc_net_master_i.put(3);
        #1 chk(acc_o, 1'b0);
        @(posedge clk);
        #1 chk(acc_o, 1'b1);
        drc_net_master_i.drop();
        wr(DRC_ADDR_CAP, 16'h000A);
        wr(DRC_ADDR_POLES, 16'h0004);
        wr(DRC_ADDR_METHOD, 16'h0014);
        @(posedge clk);
        drc_net_master_i.terms(5'h04);
        repeat (3) @(posedge clk);
        #1 chk(meth_o, DRC_M_AFV);
        wr(DRC_ADDR_INFUNC0 + 4'h2, DRC_INFUNC_VFSW);
        repeat (2) @(posedge clk);
        #1 chk(meth_o, DRC_M_VF);
        @(posedge clk);
        drc_net_master_i.terms(5'h00);
        run <= 1'b1;
        repeat (4) @(posedge clk);
        drc_net_master_i.terms(5'h04);
        repeat (3) @(posedge clk);
        #1 chk(meth_o, DRC_M_AFV);
        chk(pend_o, 1'b1);
        chk(sec_o, 1'b1);
        // Status: second set, change held, flux vector still active
        rd(DRC_ADDR_STATUS, d);
        chk(d, 16'h0032);
        @(posedge clk);
        run <= 1'b0;
        repeat (5) @(posedge clk);
        #1 chk(meth_o, DRC_M_VF);
        chk(sec_o, 1'b0);
        close_out();
    end
endmodule // tb_top
